// >>> src/pbs_cycle_ctrl.sv
// cycle decode, burst addressing, sleep and output control of the sram
`default_nettype none
`include "pbs_consts.svh"
// What this block does
// - sleep request is asynchronous, enters sleep
// - two clocks to enter and leave sleep
// - contents kept throughout sleep
// - access pending at sleep is abandoned
// - bad select with a taken strobe deselects, floats (processor strobe with first select high is not taken)
// - good selects begin read at external address
// - processor strobe start is always a read
// - writes only after processor start or controller start
// - no strobe, advance low continues read
// - no strobe, advance high suspends, same address
// - write at current address when advance high
// - write at next address when advance low
// - output enable ignored during write cycle
// - output enable is combinational, masked on writes
// - read drives data only when enabled, selected
// - global or byte-lane write enables decode
// - burst order taken from sampled select level
// - advance low increments burst counter
// - controller-started write completes same edge
module pbs_cycle_ctrl
    import pbs_pkg::*;
#(
    parameter int AW = `PBS_ADDR_W,
    parameter int LANES = `PBS_LANES
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_sleep_request,
    input wire logic i_processor_addr_strobe_n,
    input wire logic i_controller_addr_strobe_n,
    input wire logic i_burst_advance_n,
    input wire logic i_chip_sel_first_n,
    input wire logic i_chip_sel_second,
    input wire logic i_chip_sel_third_n,
    input wire logic i_global_write_n,
    input wire logic i_byte_write_enable_n,
    input wire logic [LANES-1:0] i_byte_lane_select_n,
    input wire logic i_burst_linear,
    input wire logic i_output_enable_n,
    input wire logic [AW-1:0] i_addr,
    input wire logic [LANES*`PBS_BYTE_W-1:0] i_data_in,
    input wire logic [LANES-1:0] i_parity_in,
    output logic [LANES*`PBS_BYTE_W-1:0] o_data_out,
    output logic o_data_oe,
    output logic [LANES-1:0] o_parity_out,
    output logic o_parity_oe,
    output logic o_sleep_active
);
    localparam int BW = `PBS_BURST_W;
    localparam int LW = `PBS_LANE_W;
    localparam int DW = LANES * `PBS_BYTE_W;

    // ----------------------------------------------------------------
    // sleep request synchroniser
    // ----------------------------------------------------------------
    logic [`PBS_SYNC_STAGES-1:0] sleep_sync;
    logic sleep_active;
    logic awake;

    // the request comes straight from a pin, so logic reads only the second
    // flop; the same two flops set the entry and the exit delay, which keeps
    // both at exactly two clocks with no counter to get wrong
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sleep_sync <= '0;
        end else begin
            sleep_sync <= {sleep_sync[0], i_sleep_request};
        end
    end
    assign sleep_active = sleep_sync[`PBS_SYNC_STAGES-1];
    assign awake = !sleep_active;
    assign o_sleep_active = sleep_active;

    // ----------------------------------------------------------------
    // cycle decode of the inputs present at the edge
    // ----------------------------------------------------------------
    pbs_cycle_t state;
    logic selected;
    logic ce_ok;
    logic p_go;
    logic c_go;
    logic desel;
    logic p_start;
    logic c_start;
    logic cont;
    logic [LANES-1:0] be;
    logic wr_req;
    logic mem_we;
    logic mem_re;
    logic ctr_load;
    logic ctr_step;
    logic [AW-1:0] mem_addr;
    logic [AW-BW-1:0] addr_hi;
    logic [BW-1:0] cur_lo;
    logic [BW-1:0] next_lo;

    // what each rising edge means while awake:
    //   strobe taken with a bad select  -> deselect, no access, pins float
    //   processor strobe, selects good  -> read at the pin address
    //   controller strobe, selects good -> read, or write on that same edge
    //   no strobe taken, advance low    -> step to the next burst address
    //   no strobe taken, advance high   -> stay on the current address
    // a processor strobe with the first select high is not taken at all;
    // continues count only right after a read or write cycle, so a stray
    // continue after a deselect or a sleep touches nothing
    assign selected = (state == PBS_READ) || (state == PBS_WRITE);
    assign ce_ok = !i_chip_sel_first_n && i_chip_sel_second && !i_chip_sel_third_n;
    // processor strobe is honoured only while the first select is low
    assign p_go = !i_processor_addr_strobe_n && !i_chip_sel_first_n;
    assign c_go = !i_controller_addr_strobe_n;
    assign desel = (p_go || c_go) && !ce_ok;
    assign p_start = p_go && ce_ok;
    assign c_start = !p_go && c_go && ce_ok;
    assign cont = !p_go && !c_go;

    // global write overrides, else byte enable gates the lane selects
    always_comb begin
        if (!i_global_write_n) begin
            be = `PBS_ALL_LANES;
        end else if (!i_byte_write_enable_n) begin
            be = ~i_byte_lane_select_n;
        end else begin
            be = `PBS_NO_LANES;
        end
    end
    assign wr_req = |be;

    // a processor start never writes; its write lands on a later edge
    assign mem_we = awake && wr_req && (c_start || (cont && selected));
    assign mem_re = awake && (p_start || (!wr_req && (c_start || (cont && selected))));
    assign ctr_load = awake && (p_start || c_start);
    assign ctr_step = awake && cont && selected && !i_burst_advance_n;

    // starts use the pins, continues the counter, suspends hold still
    always_comb begin
        if (p_start || c_start) begin
            mem_addr = i_addr;
        end else if (!i_burst_advance_n) begin
            mem_addr = {addr_hi, next_lo};
        end else begin
            mem_addr = {addr_hi, cur_lo};
        end
    end

    // ----------------------------------------------------------------
    // address and cycle state
    // ----------------------------------------------------------------
    // upper address bits are captured at each start only
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            addr_hi <= '0;
        end else if (ctr_load) begin
            addr_hi <= i_addr[AW-1:BW];
        end
    end

    pbs_burst_ctr #(
        .BW(BW)
    ) u_ctr (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_load(ctr_load),
        .i_start_lo(i_addr[BW-1:0]),
        .i_linear(i_burst_linear),
        .i_step(ctr_step),
        .o_cur_lo(cur_lo),
        .o_next_lo(next_lo)
    );

    // sleep drops any burst in flight; it must be restarted afterwards
    // priority runs sleep first, then write, then read
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= PBS_DESEL;
        end else begin
            case (1'b1)
                sleep_active: state <= PBS_SLEEP;
                mem_we: state <= PBS_WRITE;
                mem_re: state <= PBS_READ;
                default: state <= PBS_DESEL;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // storage and data pins
    // ----------------------------------------------------------------
    logic [LANES*LW-1:0] wdata;
    logic [LANES*LW-1:0] rdata;
    logic drive;

    for (genvar g = 0; g < LANES; g++) begin : g_pack
        assign wdata[g*LW +: LW] = {i_parity_in[g], i_data_in[g*`PBS_BYTE_W +: `PBS_BYTE_W]};
        assign o_data_out[g*`PBS_BYTE_W +: `PBS_BYTE_W] = rdata[g*LW +: `PBS_BYTE_W];
        assign o_parity_out[g] = rdata[g*LW + `PBS_BYTE_W];
    end

    // writes are blocked while asleep, so contents survive untouched
    // storage has no reset: a word never written reads back unknown
    pbs_mem #(
        .AW(AW),
        .LANES(LANES),
        .LW(LW)
    ) u_mem (
        .i_core_clk(i_core_clk),
        .i_we(mem_we),
        .i_be(be),
        .i_re(mem_re),
        .i_addr(mem_addr),
        .i_wdata(wdata),
        .o_rdata(rdata)
    );

    // first read after a deselect stays floating to avoid bank contention
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            drive <= 1'b0;
        end else begin
            drive <= mem_re && selected;
        end
    end

    // output enable is not clocked; write and deselect clear drive first
    // a plain gate lets the pins release the moment enable rises; the cost
    // is that these two outputs are not fed by a flop alone
    assign o_data_oe = drive && !i_output_enable_n;
    assign o_parity_oe = drive && !i_output_enable_n;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic [1:0] rst_age;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_age <= 2'h0;
        end else if (rst_age != 2'h3) begin
            rst_age <= rst_age + 2'h1;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sleep_entry_delay_a: assert property ((rst_age == 2'h3) |->
        sleep_active == $past(i_sleep_request, 2))
        else $error("sleep state does not follow request by two clocks");
    sleep_pins_float_a: assert property (sleep_active |=> !drive)
        else $error("data pins driven while asleep");
    sleep_no_write_a: assert property (sleep_active |-> !mem_we)
        else $error("storage written while asleep");
    deselect_float_a: assert property ((awake && desel) |=> !o_data_oe)
        else $error("data pins driven after deselect");
    processor_start_read_a: assert property ((awake && p_start) |-> mem_re && !mem_we)
        else $error("processor strobe start did not read");
    controller_write_a: assert property ((awake && c_start && wr_req)
        |-> mem_we && mem_addr == i_addr)
        else $error("controller write not taken at external address");
    write_masks_oe_a: assert property (mem_we |=> !o_data_oe && !o_parity_oe)
        else $error("output enable not masked after write");
    lane_decode_a: assert property (mem_we |-> be == (!i_global_write_n ?
        `PBS_ALL_LANES : ~i_byte_lane_select_n))
        else $error("byte lanes decoded wrongly");
    suspend_hold_a: assert property ((ctr_load ##1 (awake && cont && selected
        && i_burst_advance_n)) |-> mem_addr == $past(mem_addr))
        else $error("suspend moved the address");
    linear_step_a: assert property ((ctr_load && i_burst_linear) ##1 ctr_step
        |-> mem_addr[BW-1:0] == BW'($past(mem_addr[BW-1:0]) + BW'(1)))
        else $error("linear burst did not step by one");
    read_latency_a: assert property ((mem_re && selected) |=> o_data_oe == !i_output_enable_n)
        else $error("read data not presented one clock later");

    // ----------------------------------------------------------------
    // assertions on the cycle decode
    // ----------------------------------------------------------------
    // every start while awake reads or writes at the address on the pins
    read_external_a: assert property ((awake && (p_start || (c_start && !wr_req)))
        |-> mem_re && !mem_we && mem_addr == i_addr)
        else $error("begin read not taken at external address");
    deselect_no_access_a: assert property ((awake && desel) |-> !mem_re && !mem_we)
        else $error("deselect cycle touched the storage");
    // writes never come from a stray continue after a deselect or a sleep
    write_after_start_a: assert property ((!selected && !c_start) |-> !mem_we)
        else $error("write without a start before it");
    processor_write_a: assert property ((awake && p_start) ##1
        (awake && cont && wr_req) |-> mem_we)
        else $error("processor-started write missed its second edge");
    controller_no_read_a: assert property ((awake && c_start && wr_req) |-> !mem_re)
        else $error("controller write also read the array");
    continue_read_a: assert property ((awake && cont && selected && !wr_req
        && !i_burst_advance_n) |-> mem_re && mem_addr == {addr_hi, next_lo})
        else $error("continue read not at next burst address");
    suspend_read_a: assert property ((awake && cont && selected && !wr_req
        && i_burst_advance_n) |-> mem_re && mem_addr == {addr_hi, cur_lo})
        else $error("suspend read left the current address");
    write_current_a: assert property ((awake && cont && selected && wr_req
        && i_burst_advance_n) |-> mem_we && mem_addr == {addr_hi, cur_lo})
        else $error("suspend write not at current address");
    write_next_a: assert property ((awake && cont && selected && wr_req
        && !i_burst_advance_n) |-> mem_we && mem_addr == {addr_hi, next_lo})
        else $error("continue write not at next burst address");
    // the counter moves exactly on advance low, never on a suspend
    step_on_advance_a: assert property ((awake && cont && selected)
        |-> ctr_step == !i_burst_advance_n)
        else $error("burst counter step disagrees with advance");
    interleave_step_a: assert property ((ctr_load && !i_burst_linear) ##1 ctr_step
        |-> mem_addr[BW-1:0] == ($past(mem_addr[BW-1:0]) ^ BW'(1)))
        else $error("interleaved burst did not flip the low bit");

    // ----------------------------------------------------------------
    // assertions on sleep and the data pins
    // ----------------------------------------------------------------
    // leaving sleep never resumes the burst that sleep cut off
    sleep_drops_burst_a: assert property ($fell(sleep_active) |-> !selected)
        else $error("burst survived a sleep");
    sleep_state_a: assert property (sleep_active |=> state == PBS_SLEEP)
        else $error("cycle state did not go to sleep");
    // pins only ever drive while output enable is low at that very moment
    oe_async_a: assert property (o_data_oe |-> drive && !i_output_enable_n)
        else $error("data pins driven without output enable");
    parity_pins_pair_a: assert property (o_parity_oe == o_data_oe)
        else $error("parity pins and data pins disagree");
    // the first clock out of a deselect or a sleep keeps the pins floating
    first_read_float_a: assert property (!selected |=> !o_data_oe)
        else $error("pins driven in the first clock after a deselect");
    write_read_apart_a: assert property (mem_we |-> !mem_re)
        else $error("write and read requested on one edge");
    // a read in a selected stretch raises drive; a write or a sleep drops it
    drive_after_read_a: assert property ((mem_re && selected) |=> drive)
        else $error("drive flag not raised one clock after a read");
    drive_not_on_write_a: assert property ((mem_we || !awake) |=> !drive)
        else $error("drive flag raised after a write or while asleep");
endmodule : pbs_cycle_ctrl
`default_nettype wire

// >>> src/pbs_consts.svh
// constants of the pipelined burst cache sram cycle control
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH
`define PBS_ADDR_W 17
`define PBS_LANES 4
`define PBS_LANE_W 9
`define PBS_BYTE_W 8
`define PBS_BURST_W 2
`define PBS_SYNC_STAGES 2
// sleep entry and recovery, in clock periods as printed
`define PBS_SLEEP_ENTRY_TCYC 2
`define PBS_SLEEP_RECOVERY_TCYC 2
`define PBS_ALL_LANES 4'hf
`define PBS_NO_LANES 4'h0
`endif

// >>> src/pbs_pkg.sv
// types shared by the burst sram cycle control
`default_nettype none
package pbs_pkg;
    // gray coded along deselect -> read -> write
    typedef enum logic [1:0] {
        PBS_DESEL = 2'b00,
        PBS_READ  = 2'b01,
        PBS_WRITE = 2'b11,
        PBS_SLEEP = 2'b10
    } pbs_cycle_t;
endpackage : pbs_pkg
`default_nettype wire

// >>> src/pbs_burst_ctr.sv
// two-bit wraparound burst counter, linear or interleaved order
`default_nettype none
module pbs_burst_ctr
    import pbs_pkg::*;
#(
    parameter int BW = 2
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [BW-1:0] i_start_lo,
    input wire logic i_linear,
    input wire logic i_step,
    output logic [BW-1:0] o_cur_lo,
    output logic [BW-1:0] o_next_lo
);
    logic [BW-1:0] start;
    logic [BW-1:0] cnt;
    logic linear;
    logic [BW-1:0] cnt_inc;

    // a start captures the low bits and the order level, a step advances
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            start <= '0;
            cnt <= '0;
            linear <= 1'b0;
        end else if (i_load) begin
            start <= i_start_lo;
            cnt <= '0;
            linear <= i_linear;
        end else if (i_step) begin
            cnt <= cnt_inc;
        end
    end

    // linear adds the count and wraps, interleaved xors it
    assign cnt_inc = cnt + BW'(1);
    assign o_cur_lo = linear ? BW'(start + cnt) : (start ^ cnt);
    assign o_next_lo = linear ? BW'(start + cnt_inc) : (start ^ cnt_inc);
endmodule : pbs_burst_ctr
`default_nettype wire

// >>> src/pbs_mem.sv
// byte-lane writable storage array with registered read data
`default_nettype none
module pbs_mem #(
    parameter int AW = 17,
    parameter int LANES = 4,
    parameter int LW = 9
) (
    input wire logic i_core_clk,
    input wire logic i_we,
    input wire logic [LANES-1:0] i_be,
    input wire logic i_re,
    input wire logic [AW-1:0] i_addr,
    input wire logic [LANES*LW-1:0] i_wdata,
    output logic [LANES*LW-1:0] o_rdata
);
    // one array per lane so unselected bytes stay untouched
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LW-1:0] mem [0:(1<<AW)-1];
        always_ff @(posedge i_core_clk) begin
            if (i_we && i_be[g]) begin
                mem[i_addr] <= i_wdata[g*LW +: LW];
            end
            if (i_re) begin
                o_rdata[g*LW +: LW] <= mem[i_addr];
            end
        end
    end
endmodule : pbs_mem
`default_nettype wire

// >>> tb/pbs_ctrl_model.sv
// bus master model standing in for the cache controller in front of the sram
`default_nettype none
module pbs_ctrl_model (
    input wire logic i_core_clk,
    output logic o_sleep_request,
    output logic o_processor_addr_strobe_n,
    output logic o_controller_addr_strobe_n,
    output logic o_burst_advance_n,
    output logic o_chip_sel_first_n,
    output logic o_chip_sel_second,
    output logic o_chip_sel_third_n,
    output logic o_global_write_n,
    output logic o_byte_write_enable_n,
    output logic [3:0] o_byte_lane_select_n,
    output logic o_burst_linear,
    output logic o_output_enable_n,
    output logic [16:0] o_addr,
    output logic [35:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle and deselected from time zero
    initial begin
        o_sleep_request = 1'b0;
        o_processor_addr_strobe_n = 1'b1;
        o_controller_addr_strobe_n = 1'b1;
        o_burst_advance_n = 1'b1;
        o_chip_sel_first_n = 1'b1;
        o_chip_sel_second = 1'b0;
        o_chip_sel_third_n = 1'b1;
        o_global_write_n = 1'b1;
        o_byte_write_enable_n = 1'b1;
        o_byte_lane_select_n = 4'hf;
        o_burst_linear = 1'b1;
        o_output_enable_n = 1'b0;
        o_addr = 17'h0;
        o_wdata = 36'h0;
    end

    // one bus cycle: 0 idle, 1 controller start, 2 processor start, 3 continue, 4 deselect
    task automatic drive(input int mode, input logic adv_n, input logic gw_n,
                         input logic bwe_n, input logic [3:0] lane_n,
                         input logic [16:0] addr, input logic [35:0] data);
        logic wr;
        logic start;
        wr = !gw_n || (!bwe_n && lane_n != 4'hf);
        start = (mode == 1 || mode == 2 || mode == 4);
        @(negedge i_core_clk);
        o_processor_addr_strobe_n = (mode != 2);
        o_controller_addr_strobe_n = !(mode == 1 || mode == 4);
        o_burst_advance_n = adv_n;
        o_chip_sel_first_n = !start;
        o_chip_sel_second = start && mode != 4;
        o_chip_sel_third_n = !start;
        o_global_write_n = gw_n;
        o_byte_write_enable_n = bwe_n;
        o_byte_lane_select_n = lane_n;
        o_output_enable_n = wr;
        // lines not carrying a value toggle so stale data never looks valid
        o_addr = start ? addr : ~o_addr;
        o_wdata = wr ? data : ~o_wdata;
        @(posedge i_core_clk);
        #1;
    endtask : drive

    // deselect before raising, stay inactive after lowering
    task automatic sleep_to(input logic lvl);
        drive(lvl ? 4 : 0, 1'b1, 1'b1, 1'b1, 4'hf, 17'h0, 36'h0);
        @(negedge i_core_clk);
        o_sleep_request = lvl;
    endtask : sleep_to
endmodule : pbs_ctrl_model
`default_nettype wire

// >>> tb/test_pbs_cycle_ctrl.sv
// self-checking bench for the burst sram cycle control
`default_nettype none
module test_pbs_cycle_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CST = 1;
    localparam int PST = 2;
    localparam int CONT = 3;
    localparam int DSEL = 4;
    logic core_clk, rst, sleep_request, processor_addr_strobe_n, controller_addr_strobe_n;
    logic burst_advance_n, chip_sel_first_n, chip_sel_second, chip_sel_third_n;
    logic global_write_n, byte_write_enable_n, burst_linear, output_enable_n;
    logic data_oe, parity_oe, sleep_active;
    logic [3:0] byte_lane_select_n, parity_out;
    logic [16:0] addr;
    logic [35:0] wdata, rdata;
    logic [31:0] data_out;
    int errors = 0;
    int cmp_count = 0;

    assign rdata = {parity_out, data_out};

    pbs_ctrl_model u_pbs_ctrl_model (
        .i_core_clk(core_clk), .o_sleep_request(sleep_request),
        .o_processor_addr_strobe_n(processor_addr_strobe_n),
        .o_controller_addr_strobe_n(controller_addr_strobe_n),
        .o_burst_advance_n(burst_advance_n), .o_chip_sel_first_n(chip_sel_first_n),
        .o_chip_sel_second(chip_sel_second), .o_chip_sel_third_n(chip_sel_third_n),
        .o_global_write_n(global_write_n), .o_byte_write_enable_n(byte_write_enable_n),
        .o_byte_lane_select_n(byte_lane_select_n), .o_burst_linear(burst_linear),
        .o_output_enable_n(output_enable_n), .o_addr(addr), .o_wdata(wdata)
    );

    pbs_cycle_ctrl u_pbs_cycle_ctrl (
        .i_core_clk(core_clk), .i_rst(rst), .i_sleep_request(sleep_request),
        .i_processor_addr_strobe_n(processor_addr_strobe_n),
        .i_controller_addr_strobe_n(controller_addr_strobe_n),
        .i_burst_advance_n(burst_advance_n), .i_chip_sel_first_n(chip_sel_first_n),
        .i_chip_sel_second(chip_sel_second), .i_chip_sel_third_n(chip_sel_third_n),
        .i_global_write_n(global_write_n), .i_byte_write_enable_n(byte_write_enable_n),
        .i_byte_lane_select_n(byte_lane_select_n), .i_burst_linear(burst_linear),
        .i_output_enable_n(output_enable_n), .i_addr(addr), .i_data_in(wdata[31:0]),
        .i_parity_in(wdata[35:32]), .o_data_out(data_out), .o_data_oe(data_oe),
        .o_parity_out(parity_out), .o_parity_oe(parity_oe), .o_sleep_active(sleep_active)
    );

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    function automatic logic [35:0] pat(input int i);
        return {i[3:0], 32'hc0de_0000 + i[31:0]};
    endfunction : pat

    task automatic cyc(input int m, input logic adv_n, input logic gw_n, input logic bwe_n,
                       input logic [3:0] ln, input logic [16:0] a, input logic [35:0] d);
        u_pbs_ctrl_model.drive(m, adv_n, gw_n, bwe_n, ln, a, d);
    endtask : cyc

    // four words written, linear burst 2, 3, 0 with wrap, suspend, then output enable dropped mid-read
    task automatic t_burst();
        for (int i = 0; i < 4; i++) begin
            cyc(CST, 1'b1, 1'b0, 1'b1, 4'hf, 17'h100 + 17'(i), pat(i));
        end
        cyc(CST, 1'b1, 1'b1, 1'b1, 4'hf, 17'h102, 36'h0);
        check(rdata, pat(2));
        check({35'h0, data_oe}, 36'h1);
        cyc(CONT, 1'b0, 1'b1, 1'b1, 4'hf, 17'h0, 36'h0);
        check(rdata, pat(3));
        cyc(CONT, 1'b0, 1'b1, 1'b1, 4'hf, 17'h0, 36'h0);
        check(rdata, pat(0));
        cyc(CONT, 1'b1, 1'b1, 1'b1, 4'hf, 17'h0, 36'h0);
        check(rdata, pat(0));
        check({35'h0, data_oe}, 36'h1);
        @(negedge core_clk);
        u_pbs_ctrl_model.o_output_enable_n = 1'b1;
        #1;
        check({34'h0, data_oe, parity_oe}, 36'h0);
    endtask : t_burst

    // lanes 0 and 2 written, then a byte-enable-off start must only read
    task automatic t_bytes();
        cyc(CST, 1'b1, 1'b1, 1'b0, 4'b1010, 17'h101, 36'hf_ffff_ffff);
        cyc(CST, 1'b1, 1'b1, 1'b1, 4'h0, 17'h101, 36'h0);
        check(rdata, 36'h5_c0ff_00ff);
        cyc(CST, 1'b1, 1'b1, 1'b1, 4'hf, 17'h101, 36'h0);
        check(rdata, 36'h5_c0ff_00ff);
    endtask : t_bytes

    // processor start ignores write inputs; writes land on the following clocks
    task automatic t_pstart();
        cyc(PST, 1'b1, 1'b0, 1'b1, 4'hf, 17'h102, 36'h0);
        check(rdata, pat(2));
        cyc(CONT, 1'b1, 1'b1, 1'b1, 4'hf, 17'h0, 36'h0);
        check(rdata, pat(2));
        cyc(CONT, 1'b1, 1'b0, 1'b1, 4'hf, 17'h0, 36'ha_1111_1111);
        @(negedge core_clk);
        u_pbs_ctrl_model.o_output_enable_n = 1'b0;
        #1;
        check({35'h0, data_oe}, 36'h0);
        @(posedge core_clk);
        #1;
        check({35'h0, data_oe}, 36'h0);
        cyc(CONT, 1'b0, 1'b0, 1'b1, 4'hf, 17'h0, 36'hb_2222_2222);
        cyc(CST, 1'b1, 1'b1, 1'b1, 4'hf, 17'h102, 36'h0);
        check(rdata, 36'ha_1111_1111);
        cyc(CONT, 1'b0, 1'b1, 1'b1, 4'hf, 17'h0, 36'h0);
        check(rdata, 36'hb_2222_2222);
    endtask : t_pstart

    // deselect floats the pins; interleaved order from a start of 1 goes to 0
    task automatic t_desel();
        cyc(DSEL, 1'b1, 1'b1, 1'b1, 4'hf, 17'h0, 36'h0);
        check({34'h0, data_oe, parity_oe}, 36'h0);
        @(negedge core_clk);
        u_pbs_ctrl_model.o_burst_linear = 1'b0;
        cyc(CST, 1'b1, 1'b1, 1'b1, 4'hf, 17'h101, 36'h0);
        check({35'h0, data_oe}, 36'h0);
        cyc(CONT, 1'b0, 1'b1, 1'b1, 4'hf, 17'h0, 36'h0);
        check(rdata, pat(0));
        @(negedge core_clk);
        u_pbs_ctrl_model.o_burst_linear = 1'b1;
    endtask : t_desel

    // two clocks in and out of sleep; a write while asleep must not land
    task automatic t_sleep();
        cyc(CST, 1'b1, 1'b1, 1'b1, 4'hf, 17'h101, 36'h0);
        check(rdata, 36'h5_c0ff_00ff);
        for (int k = 1; k >= 0; k--) begin
            u_pbs_ctrl_model.sleep_to(k[0]);
            @(posedge core_clk);
            #1;
            check({35'h0, sleep_active}, {35'h0, !k[0]});
            @(posedge core_clk);
            #1;
            check({35'h0, sleep_active}, {35'h0, k[0]});
            if (k == 1) begin
                cyc(CST, 1'b1, 1'b0, 1'b1, 4'hf, 17'h102, 36'h0);
                check({34'h0, data_oe, parity_oe}, 36'h0);
                cyc(CST, 1'b1, 1'b1, 1'b1, 4'hf, 17'h100, 36'h0);
                check(rdata, 36'h5_c0ff_00ff);
            end
        end
        repeat (2) @(posedge core_clk);
        cyc(CST, 1'b1, 1'b1, 1'b1, 4'hf, 17'h102, 36'h0);
        check(rdata, 36'ha_1111_1111);
    endtask : t_sleep

    // free-running clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // reset, then every scenario in turn
    initial begin
        rst = 1'b1;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        t_burst();
        t_bytes();
        t_pstart();
        t_desel();
        t_sleep();
        close_out();
    end

    // the scenarios need well under 200 clocks; a hang ends the run here
    initial begin
        repeat (2000) @(posedge core_clk);
        errors++;
        close_out();
    end
endmodule : test_pbs_cycle_ctrl
`default_nettype wire
